// File: hw/gpa_regs.svh
// Register offsets, reset values and widths of the general-purpose port.
// Assumes inclusion by bare name; definitions only.
`ifndef GPA_REGS_SVH
`define GPA_REGS_SVH

// -----------------------------------------------------------------
// Geometry
// -----------------------------------------------------------------
`define GPA_WIDTH 8
`define GPA_ADDR_W 8

// -----------------------------------------------------------------
// Register offsets
// -----------------------------------------------------------------
`define GPA_OFS_INPUT 8'hd0
`define GPA_OFS_OUTPUT 8'hd1
`define GPA_OFS_DIR 8'hd2
`define GPA_OFS_FUNC 8'hd3

// -----------------------------------------------------------------
// Reset values
// -----------------------------------------------------------------
`define GPA_RST_DIR 8'h00
`define GPA_RST_FUNC 8'h00
`define GPA_RST_OUTPUT 8'h00
`define GPA_RST_INPUT 8'h00
`define GPA_RD_IDLE 8'h00

`endif

// File: hw/gpa_pkg.sv
// Types shared by the port modules.
// Assumes gpa_regs.svh is on the include path.
`include "gpa_regs.svh"

package gpa_pkg;

  // -----------------------------------------------------------------
  // Data types
  // -----------------------------------------------------------------
  typedef logic [`GPA_WIDTH-1:0] gpa_byte_t;
  typedef logic [`GPA_ADDR_W-1:0] gpa_addr_t;

  // One-hot register select
  typedef enum logic [4:0] {
    GPA_SEL_NONE = 5'h01,
    GPA_SEL_IN = 5'h02,
    GPA_SEL_OUT = 5'h04,
    GPA_SEL_DIR = 5'h08,
    GPA_SEL_FUNC = 5'h10
  } gpa_sel_t;

  // Top-level register state
  typedef struct packed {
    gpa_byte_t in_val;
    gpa_byte_t out_val;
    gpa_byte_t dir;
    gpa_byte_t func;
    gpa_byte_t rdata;
  } gpa_regs_t;

  // Synchroniser state
  typedef struct packed {
    gpa_byte_t stage1;
    gpa_byte_t stage2;
  } gpa_sync_t;

  // Pin driver state
  typedef struct packed {
    gpa_byte_t pin_out;
    gpa_byte_t pin_oe_n;
    gpa_byte_t schmitt_en;
  } gpa_drv_t;

endpackage : gpa_pkg

// File: hw/gpa_pin_if.sv
// Carrier between the register file and the pin driver.
// Assumes both ends share one clock.
`timescale 1ns/1ps

interface gpa_pin_if;
  import gpa_pkg::*;

  gpa_byte_t dir;
  gpa_byte_t out_val;
  gpa_byte_t od_sel;
  gpa_byte_t pin_out;
  gpa_byte_t pin_oe_n;
  gpa_byte_t schmitt_en;

  modport ctrl (
    output dir,
    output out_val,
    output od_sel,
    input pin_out,
    input pin_oe_n,
    input schmitt_en
  );

  modport drv (
    input dir,
    input out_val,
    input od_sel,
    output pin_out,
    output pin_oe_n,
    output schmitt_en
  );
endinterface : gpa_pin_if

// File: hw/gpa_sync.sv
// Two-stage synchroniser for the port pins.
// Assumes pins are asynchronous to i_clk.
`timescale 1ns/1ps

module gpa_sync (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire gpa_pkg::gpa_byte_t i_d,
  output gpa_pkg::gpa_byte_t o_q
);
  import gpa_pkg::*;

  gpa_sync_t st_r;
  gpa_sync_t st_nxt;

  // -----------------------------------------------------------------
  // Two flop stages; first stage feeds only the second
  // -----------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.stage1 = i_d;
    st_nxt.stage2 = st_r.stage1;
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign o_q = st_r.stage2;

endmodule : gpa_sync

// File: hw/gpa_pin_drv.sv
// Pin driver: push-pull or open-drain, plus input buffer enable.
// Assumes the pad resolves the wire from the active-low enable.
`timescale 1ns/1ps
`include "gpa_regs.svh"

module gpa_pin_drv (
  input wire logic i_clk,
  input wire logic i_rst_n,
  gpa_pin_if.drv pif
);
  import gpa_pkg::*;

  gpa_drv_t st_r;
  gpa_drv_t st_nxt;

  // -----------------------------------------------------------------
  // Drive selection
  // -----------------------------------------------------------------
  // Open-drain drives only a low; a high releases the pin.
  always_comb
  begin
    st_nxt = st_r;
    for (int b = 0; b < `GPA_WIDTH; b++)
    begin
      if (pif.dir[b])
      begin
        if (pif.od_sel[b])
        begin
          st_nxt.pin_out[b] = 1'b0;
          st_nxt.pin_oe_n[b] = pif.out_val[b];
        end
        else
        begin
          st_nxt.pin_out[b] = pif.out_val[b];
          st_nxt.pin_oe_n[b] = 1'b0;
        end
      end
      else
      begin
        // Output bit of an input pin has no hardware effect
        st_nxt.pin_out[b] = 1'b0;
        st_nxt.pin_oe_n[b] = 1'b1;
      end
      st_nxt.schmitt_en[b] = ~pif.dir[b];
    end
  end

  // Reset leaves every pin released, buffers on
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st_r.pin_out <= 8'h00;
      st_r.pin_oe_n <= 8'hff;
      st_r.schmitt_en <= 8'hff;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign pif.pin_out = st_r.pin_out;
  assign pif.pin_oe_n = st_r.pin_oe_n;
  assign pif.schmitt_en = st_r.schmitt_en;

endmodule : gpa_pin_drv

// File: hw/gpa_port.sv
// Bit-wise general-purpose port: register file, synchroniser, driver.
// Assumes a single-cycle strobe bus on i_clk and pins from the pad ring.
//
// Behaviour
// - Direction bit 1 output, 0 input
// - Input pins pass two stages first
// - Input write overwritten next cycle by sample
// - Output bits keep written input value
// - Output bits never sample own pin
// - Output pin driven from output register
// - Unused register bit holds, no effect
// - Output register reads held value
// - Output bits disable input buffer
// - Output updates on rising clock edge
// - Any register access order, any time
// - Function bit picks push-pull or open-drain
// - Direction register at address d2
// - Reset clears all direction bits
// - Reset clears function register
`timescale 1ns/1ps
`include "gpa_regs.svh"

module gpa_port (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire gpa_pkg::gpa_addr_t i_addr,
  input wire gpa_pkg::gpa_byte_t i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output gpa_pkg::gpa_byte_t o_rdata,
  input wire gpa_pkg::gpa_byte_t i_pin,
  output gpa_pkg::gpa_byte_t o_pin_out,
  output gpa_pkg::gpa_byte_t o_pin_oe_n,
  output gpa_pkg::gpa_byte_t o_schmitt_en
);
  import gpa_pkg::*;

  gpa_regs_t st_r;
  gpa_regs_t st_nxt;
  gpa_byte_t pin_sync;
  gpa_sel_t sel;

  gpa_pin_if pif ();

  // -----------------------------------------------------------------
  // Address decode
  // -----------------------------------------------------------------
  function automatic gpa_sel_t decode(input gpa_addr_t addr);
    gpa_sel_t s;
    s = GPA_SEL_NONE;
    case (addr)
      `GPA_OFS_INPUT: s = GPA_SEL_IN;
      `GPA_OFS_OUTPUT: s = GPA_SEL_OUT;
      `GPA_OFS_DIR: s = GPA_SEL_DIR;
      `GPA_OFS_FUNC: s = GPA_SEL_FUNC;
      default: s = GPA_SEL_NONE;
    endcase
    return s;
  endfunction : decode

  assign sel = decode(i_addr);

  // -----------------------------------------------------------------
  // Pin synchroniser
  // -----------------------------------------------------------------
  gpa_sync u_sync (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_d(i_pin),
    .o_q(pin_sync)
  );

  // -----------------------------------------------------------------
  // Register file
  // -----------------------------------------------------------------
  // Registers are independent, so no access ordering is imposed.
  always_comb
  begin
    st_nxt = st_r;
    // Input pins reload the sample; output pins hold the last write
    st_nxt.in_val = (st_r.in_val & st_r.dir)
      | (pin_sync & ~st_r.dir);
    st_nxt.rdata = `GPA_RD_IDLE;
    if (i_wr)
    begin
      unique case (sel)
        GPA_SEL_IN: st_nxt.in_val = i_wdata;
        GPA_SEL_OUT: st_nxt.out_val = i_wdata;
        GPA_SEL_DIR: st_nxt.dir = i_wdata;
        GPA_SEL_FUNC: st_nxt.func = i_wdata;
        GPA_SEL_NONE: st_nxt.rdata = `GPA_RD_IDLE;
      endcase
    end
    if (i_rd)
    begin
      unique case (sel)
        GPA_SEL_IN: st_nxt.rdata = st_r.in_val;
        GPA_SEL_OUT: st_nxt.rdata = st_r.out_val;
        GPA_SEL_DIR: st_nxt.rdata = st_r.dir;
        GPA_SEL_FUNC: st_nxt.rdata = st_r.func;
        GPA_SEL_NONE: st_nxt.rdata = `GPA_RD_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st_r.in_val <= `GPA_RST_INPUT;
      st_r.out_val <= `GPA_RST_OUTPUT;
      st_r.dir <= `GPA_RST_DIR;
      st_r.func <= `GPA_RST_FUNC;
      st_r.rdata <= `GPA_RD_IDLE;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // -----------------------------------------------------------------
  // Pin driver
  // -----------------------------------------------------------------
  // Costs one cycle from register write to pad, keeps pads glitch-free.
  assign pif.dir = st_r.dir;
  assign pif.out_val = st_r.out_val;
  assign pif.od_sel = st_r.func;

  gpa_pin_drv u_drv (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .pif(pif)
  );

  assign o_rdata = st_r.rdata;
  assign o_pin_out = pif.pin_out;
  assign o_pin_oe_n = pif.pin_oe_n;
  assign o_schmitt_en = pif.schmitt_en;

endmodule : gpa_port

// File: tb/gpa_port_monitor.sv
// Concurrent checks on the port's register bus and pad outputs.
// Assumes it is bound to gpa_port and sees only its ports.
`timescale 1ns/1ps

module gpa_port_monitor (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire gpa_pkg::gpa_addr_t i_addr,
  input wire gpa_pkg::gpa_byte_t i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire gpa_pkg::gpa_byte_t o_rdata,
  input wire gpa_pkg::gpa_byte_t i_pin,
  input wire gpa_pkg::gpa_byte_t o_pin_out,
  input wire gpa_pkg::gpa_byte_t o_pin_oe_n,
  input wire gpa_pkg::gpa_byte_t o_schmitt_en
);
  import gpa_pkg::*;
  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  sequence s_wr(a);
    i_wr && i_addr == a;
  endsequence
  sequence s_rd(a);
    i_rd && i_addr == a;
  endsequence
  chk_rd_idle: assert property (
    !$past(i_rd) |-> o_rdata == 8'h00) else $error("read data not idle");
  chk_dir_read: assert property (
    s_wr(8'hd2) ##1 s_rd(8'hd2) |=> o_rdata == $past(i_wdata, 2))
    else $error("direction readback");
  chk_out_read: assert property (
    s_wr(8'hd1) ##1 s_rd(8'hd1) |=> o_rdata == $past(i_wdata, 2))
    else $error("output readback");
  chk_buf_off: assert property (
    s_wr(8'hd2) ##1 !i_wr |=> o_schmitt_en == ~$past(i_wdata, 2))
    else $error("buffer enable");
  chk_no_contra: assert property (
    ((o_pin_out & o_pin_oe_n) | (o_schmitt_en & ~o_pin_oe_n)) == 8'h00)
    else $error("pad drive");
  // Four steady samples fill both stages and the input register
  chk_in_sync: assert property (
    ($stable(i_pin) && !i_wr && o_schmitt_en == 8'hff)[*4]
    ##0 s_rd(8'hd0) |=> o_rdata == $past(i_pin)) else $error("input sample");
  chk_in_wr_seen: assert property (
    s_wr(8'hd0) ##1 s_rd(8'hd0) |=> o_rdata == $past(i_wdata, 2))
    else $error("input write");
  chk_in_held: assert property (
    s_wr(8'hd0) ##1 !i_wr ##1 (s_rd(8'hd0) ##0 o_schmitt_en == 8'h00)
    |=> o_rdata == $past(i_wdata, 3)) else $error("input hold");
endmodule : gpa_port_monitor

bind gpa_port gpa_port_monitor u_mon (.i_clk(i_clk), .i_rst_n(i_rst_n),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
  .o_rdata(o_rdata), .i_pin(i_pin), .o_pin_out(o_pin_out),
  .o_pin_oe_n(o_pin_oe_n), .o_schmitt_en(o_schmitt_en));

// File: tb/gpa_board.sv
// Board around the pads: pull-ups plus an external driver.
// Assumes the bench chooses which lines the board drives.
`timescale 1ns/1ps

module gpa_board (
  input wire gpa_pkg::gpa_byte_t i_pin_out,
  input wire gpa_pkg::gpa_byte_t i_pin_oe_n,
  input wire gpa_pkg::gpa_byte_t i_ext_val,
  input wire gpa_pkg::gpa_byte_t i_ext_en,
  output gpa_pkg::gpa_byte_t o_pin
);
  import gpa_pkg::*;
  // External drive wins to model contention; released lines pull up
  assign o_pin = (i_ext_en & i_ext_val) | (~i_ext_en & ~i_pin_oe_n
    & i_pin_out) | (~i_ext_en & i_pin_oe_n);
endmodule : gpa_board

// File: tb/gpa_port_tb_top.sv
// Self-checking bench for the general-purpose port.
// Assumes the design package and the board model are compiled first.
`timescale 1ns/1ps

module gpa_port_tb_top;
  import gpa_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  gpa_addr_t i_addr = 8'h00;
  gpa_byte_t i_wdata = 8'h00;
  gpa_byte_t ext_val = 8'h00;
  gpa_byte_t ext_en = 8'h00;
  gpa_byte_t o_rdata;
  gpa_byte_t i_pin;
  gpa_byte_t o_pin_out;
  gpa_byte_t o_pin_oe_n;
  gpa_byte_t o_schmitt_en;
  int failures = 0;
  int check_count = 0;

  always #25 i_clk = ~i_clk;

  gpa_port DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_pin(i_pin), .o_pin_out(o_pin_out), .o_pin_oe_n(o_pin_oe_n),
    .o_schmitt_en(o_schmitt_en));
  gpa_board u_board (.i_pin_out(o_pin_out), .i_pin_oe_n(o_pin_oe_n),
    .i_ext_val(ext_val), .i_ext_en(ext_en), .o_pin(i_pin));

  // ---------------------------------------------------------------
  // Bus and check helpers
  // ---------------------------------------------------------------
  task automatic check(input string n, input gpa_byte_t s, gpa_byte_t e);
    check_count++;
    if (s !== e)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : check
  // Signals change by NBA right after a rising edge, once per edge
  task automatic bus(input logic w, r, gpa_addr_t a, gpa_byte_t d);
    i_wr <= w;
    i_rd <= r;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
  endtask : bus
  task automatic idle(input int n);
    repeat (n) bus(1'b0, 1'b0, 8'h00, 8'h00);
  endtask : idle
  // Read data stand one cycle only, so look at them mid-cycle
  task automatic rd(input gpa_addr_t a, gpa_byte_t e, string n);
    bus(1'b0, 1'b1, a, 8'h00);
    i_rd <= 1'b0;
    i_addr <= 8'h00;
    @(negedge i_clk);
    check(n, o_rdata, e);
    @(posedge i_clk);
  endtask : rd
  task automatic test_done();
    if (failures == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : test_done

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    check("oe_n", o_pin_oe_n, 8'hff);
    check("buffer", o_schmitt_en, 8'hff);
    rd(8'hd2, 8'h00, "dir");
    rd(8'hd3, 8'h00, "func");
    rd(8'hc0, 8'h00, "unmapped");
  endtask : t_reset
  task automatic t_input();
    ext_en <= 8'hff;
    ext_val <= 8'h5a;
    idle(5);
    rd(8'hd0, 8'h5a, "in sync");
    bus(1'b1, 1'b0, 8'hd0, 8'ha5);
    rd(8'hd0, 8'ha5, "in written");
    rd(8'hd0, 8'h5a, "in resampled");
  endtask : t_input
  task automatic t_output();
    bus(1'b1, 1'b0, 8'hd3, 8'h00);
    bus(1'b1, 1'b0, 8'hd1, 8'h3c);
    rd(8'hd1, 8'h3c, "out reg");
    ext_en <= 8'h00;
    bus(1'b1, 1'b0, 8'hd2, 8'hff);
    rd(8'hd2, 8'hff, "dir reg");
    bus(1'b1, 1'b0, 8'hd0, 8'ha5);
    idle(1);
    rd(8'hd0, 8'ha5, "in held");
    bus(1'b1, 1'b0, 8'hd2, 8'h0f);
    ext_en <= 8'hf0;
    ext_val <= 8'h5a;
    idle(4);
    check("pin out", o_pin_out, 8'h0c);
    check("oe_n mix", o_pin_oe_n, 8'hf0);
    check("buffer mix", o_schmitt_en, 8'hf0);
    rd(8'hd0, 8'h55, "in mixed");
    ext_en <= 8'hff;
    ext_val <= 8'h00;
    idle(2);
    rd(8'hd1, 8'h3c, "out contended");
    ext_en <= 8'hf0;
  endtask : t_output
  task automatic t_open_drain();
    bus(1'b1, 1'b0, 8'hd3, 8'h0f);
    idle(2);
    check("od out", o_pin_out, 8'h00);
    check("od oe_n", o_pin_oe_n, 8'hfc);
    rd(8'hd3, 8'h0f, "func reg");
  endtask : t_open_drain

  initial
  begin
    repeat (4) @(posedge i_clk);
    i_rst_n <= 1'b1;
    t_reset();
    t_input();
    t_output();
    t_open_drain();
    test_done();
  end
  initial
  begin
    repeat (500) @(posedge i_clk);
    failures++;
    test_done();
  end
endmodule : gpa_port_tb_top
